/* src/serial_port_transmitter.sv */
// Transmit side of the enhanced serial port: holding register, shift register,
// asynchronous framing and synchronous master clock generation.
// Assumes software writes registers through the strobe port on clk_sys.
//
// Functional notes
// - Shift-empty status reads one while shift register empty, clears on load until done.
// - Shift-empty status raises no interrupt; software polls it.
// - Shift register has no address; software cannot read or write it.
// - Nine-bit mode sends nine data bits; ninth bit is the top bit.
// - Holding write moves all nine bits into shift register together.
// - Set ninth bit marks the character as an address for receivers.
// - Polarity select inverts the asynchronous output.
// - Transmit enable starts transmitter and sets the ready flag.
// - Interrupt raised at once when all enables set and ready flag set.
// - Writing the holding register starts transmission of that character.
// - New character waits in holding register while shift register busy.
// - Synchronous characters have no start or stop bits.
// - Synchronous link is one data line and one master clock, half duplex.
// - Synchronous master drives clock pin, driver on whenever sync master configured and port enabled.
// - Exactly one clock cycle per data bit, no extra cycles.
// - Data change on leading edge, stay valid through trailing edge.
// - Polarity set idles clock high; cleared idles low.
// - Master transmit drives data pin; clock driver always on, data driver only while both receive enables clear.
// - Shifting starts right after transfer into the shift register.
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ns

module serial_port_transmitter (
  // Clock and reset
  input  wire logic                           clk_sys,
  input  wire logic                           resetn,
  // Register port
  input  wire serial_tx_pkg::reg_req_s        reg_req,
  output logic [serial_tx_pkg::DATA_W-1:0]    reg_rdata,
  // Pins
  output serial_tx_pkg::pin_out_s             pins,
  // Interrupt request toward the core
  output logic                                tx_irq
);

  typedef struct packed {
    logic [serial_tx_pkg::CTL_W-1:0]  ctl;
    logic [serial_tx_pkg::DIV_W-1:0]  div;
    logic [serial_tx_pkg::CHAR_W-1:0] hold;
    logic                             hold_full;
    logic [serial_tx_pkg::CHAR_W-1:0] shift;
    logic [3:0]                       bits_left;
    serial_tx_pkg::tx_state_e         state;
    logic [serial_tx_pkg::DIV_W-1:0]  cnt;
    logic                             phase;
    logic                             line;
    logic                             clk_line;
    logic [serial_tx_pkg::DATA_W-1:0] rdata;
  } state_s;

  state_s st_reg;
  state_s st_next;

  logic sync_mode;
  logic port_on;
  logic tx_on;
  logic pol;
  logic nine;
  logic shift_empty;
  logic tick;

  assign sync_mode   = st_reg.ctl[serial_tx_pkg::CTL_SYNC];
  assign port_on     = st_reg.ctl[serial_tx_pkg::CTL_ENABLE];
  assign tx_on       = st_reg.ctl[serial_tx_pkg::CTL_TX_EN] & port_on;
  assign pol         = st_reg.ctl[serial_tx_pkg::CTL_POL];
  assign nine        = st_reg.ctl[serial_tx_pkg::CTL_NINE];
  assign shift_empty = (st_reg.state == serial_tx_pkg::ST_IDLE);
  assign tick        = (st_reg.cnt == '0);

  always_comb begin
    logic load;
    logic wr_hold;
    load    = 1'b0;
    wr_hold = 1'b0;
    st_next = st_reg;
    st_next.cnt = tick ? st_reg.div : st_reg.cnt - 1'b1;

    if (reg_req.wr) begin
      case (reg_req.addr)
        serial_tx_pkg::ADDR_CONTROL: st_next.ctl = reg_req.wdata[serial_tx_pkg::CTL_W-1:0];
        serial_tx_pkg::ADDR_DIVIDER: st_next.div = reg_req.wdata;
        serial_tx_pkg::ADDR_HOLDING: wr_hold = tx_on;
        default: ;
      endcase
    end
    // Ninth bit comes from the control field present at write time
    if (wr_hold) begin
      st_next.hold      = {st_next.ctl[serial_tx_pkg::CTL_NINTH], reg_req.wdata[7:0]};
      st_next.hold_full = 1'b1;
    end

    case (st_reg.state)
      serial_tx_pkg::ST_IDLE: begin
        st_next.phase = 1'b0;
        if (st_next.hold_full && tx_on) begin
          load = 1'b1;
        end
      end
      serial_tx_pkg::ST_START: begin
        if (tick) begin
          st_next.state = serial_tx_pkg::ST_DATA;
        end
      end
      serial_tx_pkg::ST_DATA: begin
        if (tick) begin
          if (sync_mode && !st_reg.phase) begin
            st_next.phase = 1'b1;  // Trailing half of the bit
          end else begin
            st_next.phase = 1'b0;
            st_next.shift = st_reg.shift >> 1;
            st_next.bits_left = st_reg.bits_left - 1'b1;
            if (st_reg.bits_left == serial_tx_pkg::BIT_ONE) begin
              // Sync mode skips the stop bit
              st_next.state = sync_mode ? serial_tx_pkg::ST_IDLE : serial_tx_pkg::ST_STOP;
            end
          end
        end
      end
      serial_tx_pkg::ST_STOP: begin
        if (tick) begin
          st_next.state = serial_tx_pkg::ST_IDLE;
        end
      end
      default: st_next.state = serial_tx_pkg::ST_IDLE;
    endcase

    if (load) begin
      st_next.shift     = st_next.hold;
      st_next.hold_full = 1'b0;
      st_next.bits_left = nine ? serial_tx_pkg::BITS_NINE : serial_tx_pkg::BITS_EIGHT;
      st_next.state     = sync_mode ? serial_tx_pkg::ST_DATA : serial_tx_pkg::ST_START;
      st_next.cnt       = st_reg.div;
      st_next.phase     = 1'b0;
    end
    if (!tx_on) begin
      st_next.state     = serial_tx_pkg::ST_IDLE;
      st_next.hold_full = 1'b0;
    end

    // Line levels; async idle high, start low, stop high
    case (st_next.state)
      serial_tx_pkg::ST_START: st_next.line = 1'b0;
      serial_tx_pkg::ST_DATA:  st_next.line = st_next.shift[0];
      default:                 st_next.line = 1'b1;
    endcase
    // Clock: leading edge at bit start, trailing mid-bit; idle level is polarity
    st_next.clk_line = pol ^ (st_next.state == serial_tx_pkg::ST_DATA && !st_next.phase);

    st_next.rdata = '0;
    if (reg_req.rd) begin
      case (reg_req.addr)
        serial_tx_pkg::ADDR_CONTROL: st_next.rdata = {4'h0, st_reg.ctl};
        serial_tx_pkg::ADDR_DIVIDER: st_next.rdata = st_reg.div;
        // Shift-empty bit is status only, no interrupt path
        serial_tx_pkg::ADDR_STATUS:  st_next.rdata = {14'h0000, !st_reg.hold_full & tx_on,
                                                      shift_empty};
        default:                     st_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_reg           <= '0;
      st_reg.ctl       <= serial_tx_pkg::CTL_RESET;
      st_reg.div       <= serial_tx_pkg::DIV_RESET;
      st_reg.state     <= serial_tx_pkg::ST_IDLE;
      st_reg.line      <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  logic ready_flag;
  logic master_sync;
  assign ready_flag  = tx_on & !st_reg.hold_full;
  assign master_sync = port_on & sync_mode & st_reg.ctl[serial_tx_pkg::CTL_MASTER];
  assign reg_rdata   = st_reg.rdata;
  // Interrupt level follows ready flag at once
  assign tx_irq      = ready_flag & st_reg.ctl[serial_tx_pkg::CTL_IRQ_EN]
                       & st_reg.ctl[serial_tx_pkg::CTL_GIE] & st_reg.ctl[serial_tx_pkg::CTL_PERIPHERAL_IRQ_ENABLE];

  always_comb begin
    pins.tx_out    = 1'b1;
    pins.tx_oe_n   = 1'b1;
    pins.data_out  = 1'b1;
    pins.data_oe_n = 1'b1;
    if (master_sync) begin
      pins.tx_out    = st_reg.clk_line;
      pins.tx_oe_n   = 1'b0;
      pins.data_out  = st_reg.line;
      // Data pin driven only when not receiving, half duplex
      pins.data_oe_n = st_reg.ctl[serial_tx_pkg::CTL_SINGLE_RECEIVE_ENABLE] | st_reg.ctl[serial_tx_pkg::CTL_CONTINUOUS_RECEIVE_ENABLE];
    end else if (port_on && !sync_mode) begin
      pins.tx_out  = st_reg.line ^ pol;
      pins.tx_oe_n = 1'b0;
    end
  end

  // Assertions
  property p_empty_clears;
    @(posedge clk_sys) disable iff (!resetn)
      (shift_empty && st_next.state != serial_tx_pkg::ST_IDLE) |=> !shift_empty;
  endproperty
  a_empty_clears: assert property (p_empty_clears) else $error("empty not cleared");

  property p_irq_ready;
    @(posedge clk_sys) disable iff (!resetn)
      tx_irq |-> ready_flag;
  endproperty
  a_irq_ready: assert property (p_irq_ready) else $error("irq without ready");

  property p_load_bits;
    @(posedge clk_sys) disable iff (!resetn)
      (shift_empty && st_reg.hold_full && tx_on) |=>
        st_reg.bits_left == (nine ? serial_tx_pkg::BITS_NINE : serial_tx_pkg::BITS_EIGHT);
  endproperty
  a_load_bits: assert property (p_load_bits) else $error("bit count wrong");

  property p_wait_busy;
    @(posedge clk_sys) disable iff (!resetn)
      (!shift_empty && st_reg.hold_full && tx_on && !tick) |=> st_reg.hold_full;
  endproperty
  a_wait_busy: assert property (p_wait_busy) else $error("holding lost");

  property p_start_low;
    @(posedge clk_sys) disable iff (!resetn)
      (st_reg.state == serial_tx_pkg::ST_START) |-> !st_reg.line;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start not low");

  property p_no_sync_start;
    @(posedge clk_sys) disable iff (!resetn)
      (sync_mode && $past(sync_mode)) |-> st_reg.state != serial_tx_pkg::ST_START;
  endproperty
  a_no_sync_start: assert property (p_no_sync_start) else $error("sync framing");

  property p_clk_idle;
    @(posedge clk_sys) disable iff (!resetn)
      (master_sync && shift_empty && $stable(pol)) |-> pins.tx_out == pol;
  endproperty
  a_clk_idle: assert property (p_clk_idle) else $error("clock idle wrong");

  property p_clk_driven;
    @(posedge clk_sys) disable iff (!resetn)
      master_sync |-> !pins.tx_oe_n;
  endproperty
  a_clk_driven: assert property (p_clk_driven) else $error("clock not driven");

  property p_data_stable;
    @(posedge clk_sys) disable iff (!resetn)
      (st_reg.state == serial_tx_pkg::ST_DATA && st_reg.phase) |-> $stable(st_reg.line);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("data moved");

  // Register side checks
  property p_empty_status;
    @(posedge clk_sys) disable iff (!resetn)
      (reg_req.rd && reg_req.addr == serial_tx_pkg::ADDR_STATUS) |=>
        reg_rdata[serial_tx_pkg::ST_EMPTY] == $past(shift_empty);
  endproperty
  a_empty_status: assert property (p_empty_status) else $error("status empty bit");

  property p_empty_holds;
    @(posedge clk_sys) disable iff (!resetn)
      (!shift_empty && tx_on && !tick) |=> !shift_empty;
  endproperty
  a_empty_holds: assert property (p_empty_holds) else $error("empty set early");

  property p_shift_hidden;
    @(posedge clk_sys) disable iff (!resetn)
      (reg_req.rd && reg_req.addr == serial_tx_pkg::ADDR_HOLDING) |=> reg_rdata == '0;
  endproperty
  a_shift_hidden: assert property (p_shift_hidden) else $error("shift data visible");

  property p_ninth_bit;
    @(posedge clk_sys) disable iff (!resetn)
      (reg_req.wr && reg_req.addr == serial_tx_pkg::ADDR_HOLDING && tx_on) |=>
        st_reg.hold[serial_tx_pkg::CHAR_W-1] == st_reg.ctl[serial_tx_pkg::CTL_NINTH];
  endproperty
  a_ninth_bit: assert property (p_ninth_bit) else $error("ninth bit lost");

  property p_hold_write;
    @(posedge clk_sys) disable iff (!resetn)
      (reg_req.wr && reg_req.addr == serial_tx_pkg::ADDR_HOLDING && tx_on) |=>
        (st_reg.hold_full || !shift_empty);
  endproperty
  a_hold_write: assert property (p_hold_write) else $error("write not taken");

  property p_ready_on_enable;
    @(posedge clk_sys) disable iff (!resetn)
      (reg_req.wr && reg_req.addr == serial_tx_pkg::ADDR_CONTROL && !st_reg.hold_full
       && reg_req.wdata[serial_tx_pkg::CTL_TX_EN] && reg_req.wdata[serial_tx_pkg::CTL_ENABLE])
        |=> ready_flag;
  endproperty
  a_ready_on_enable: assert property (p_ready_on_enable) else $error("ready not set");

  property p_irq_at_once;
    @(posedge clk_sys) disable iff (!resetn)
      (ready_flag && st_reg.ctl[serial_tx_pkg::CTL_IRQ_EN] && st_reg.ctl[serial_tx_pkg::CTL_GIE]
       && st_reg.ctl[serial_tx_pkg::CTL_PERIPHERAL_IRQ_ENABLE]) |-> tx_irq;
  endproperty
  a_irq_at_once: assert property (p_irq_at_once) else $error("irq late");

  // Shift register checks
  property p_load_shift;
    @(posedge clk_sys) disable iff (!resetn)
      (shift_empty && st_next.state != serial_tx_pkg::ST_IDLE) |=>
        st_reg.shift == $past(st_next.hold);
  endproperty
  a_load_shift: assert property (p_load_shift) else $error("load mismatch");

  property p_line_bit0;
    @(posedge clk_sys) disable iff (!resetn)
      (shift_empty && st_next.state == serial_tx_pkg::ST_DATA) |=>
        st_reg.line == st_reg.shift[0];
  endproperty
  a_line_bit0: assert property (p_line_bit0) else $error("first bit wrong");

  property p_bits_bound;
    @(posedge clk_sys) disable iff (!resetn)
      (st_reg.state == serial_tx_pkg::ST_DATA) |->
        (st_reg.bits_left != '0 && st_reg.bits_left <= serial_tx_pkg::BITS_NINE);
  endproperty
  a_bits_bound: assert property (p_bits_bound) else $error("bit count range");

  // Asynchronous line checks
  property p_async_idle;
    @(posedge clk_sys) disable iff (!resetn)
      (port_on && !sync_mode && shift_empty) |-> pins.tx_out == !pol;
  endproperty
  a_async_idle: assert property (p_async_idle) else $error("idle level wrong");

  property p_stop_high;
    @(posedge clk_sys) disable iff (!resetn)
      (st_reg.state == serial_tx_pkg::ST_STOP) |-> st_reg.line;
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("stop not high");

  property p_async_invert;
    @(posedge clk_sys) disable iff (!resetn)
      (port_on && !sync_mode) |-> pins.tx_out == (st_reg.line ^ pol);
  endproperty
  a_async_invert: assert property (p_async_invert) else $error("inversion wrong");

  // Synchronous link checks
  property p_sync_no_stop;
    @(posedge clk_sys) disable iff (!resetn)
      (sync_mode && $past(sync_mode)) |-> st_reg.state != serial_tx_pkg::ST_STOP;
  endproperty
  a_sync_no_stop: assert property (p_sync_no_stop) else $error("sync stop bit");

  // Clock register lags the polarity bit by one cycle, hence the two-deep check
  property p_clk_quiet;
    @(posedge clk_sys) disable iff (!resetn)
      (master_sync && $past(master_sync) && shift_empty && $past(shift_empty)
       && $stable(pol) && $past(pol, 2) == pol) |-> $stable(pins.tx_out);
  endproperty
  a_clk_quiet: assert property (p_clk_quiet) else $error("extra clock edge");

  property p_data_leading;
    @(posedge clk_sys) disable iff (!resetn)
      (master_sync && st_reg.state == serial_tx_pkg::ST_DATA && $changed(st_reg.line)
       && $stable(pol)) |-> st_reg.clk_line != pol;
  endproperty
  a_data_leading: assert property (p_data_leading) else $error("data off leading");

  property p_data_pin;
    @(posedge clk_sys) disable iff (!resetn)
      (master_sync && !st_reg.ctl[serial_tx_pkg::CTL_SINGLE_RECEIVE_ENABLE] && !st_reg.ctl[serial_tx_pkg::CTL_CONTINUOUS_RECEIVE_ENABLE])
        |-> (!pins.data_oe_n && pins.data_out == st_reg.line);
  endproperty
  a_data_pin: assert property (p_data_pin) else $error("data pin idle");

  c_async_char: cover property (@(posedge clk_sys) st_reg.state == serial_tx_pkg::ST_STOP);
  c_nine_char:  cover property (@(posedge clk_sys) nine && st_reg.bits_left == serial_tx_pkg::BITS_NINE);
  c_inverted:   cover property (@(posedge clk_sys) port_on && !sync_mode && pol && !shift_empty);
  c_sync_char:  cover property (@(posedge clk_sys) master_sync && !shift_empty);
  c_queued:     cover property (@(posedge clk_sys) !shift_empty && st_reg.hold_full);

endmodule // serial_port_transmitter

/* src/serial_tx_pkg.sv */
// Package for the serial port transmitter: register map, control fields, states.
// Assumes a 10 MHz system clock and the simple strobe register port.
package serial_tx_pkg;

  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 16;
  localparam int          CHAR_W          = 9;
  localparam int          DIV_W           = 16;

  // Register word addresses
  localparam logic [3:0]  ADDR_CONTROL    = 4'h0;
  localparam logic [3:0]  ADDR_HOLDING    = 4'h1;
  localparam logic [3:0]  ADDR_DIVIDER    = 4'h2;
  localparam logic [3:0]  ADDR_STATUS     = 4'h3;

  // Control register fields
  localparam int          CTL_ENABLE      = 0;
  localparam int          CTL_TX_EN       = 1;
  localparam int          CTL_SYNC        = 2;
  localparam int          CTL_MASTER      = 3;
  localparam int          CTL_NINE        = 4;
  localparam int          CTL_NINTH       = 5;
  localparam int          CTL_POL         = 6;
  localparam int          CTL_SINGLE_RECEIVE_ENABLE        = 7;
  localparam int          CTL_CONTINUOUS_RECEIVE_ENABLE        = 8;
  localparam int          CTL_IRQ_EN      = 9;
  localparam int          CTL_GIE         = 10;
  localparam int          CTL_PERIPHERAL_IRQ_ENABLE        = 11;
  localparam int          CTL_W           = 12;

  // Status register fields
  localparam int          ST_EMPTY        = 0;
  localparam int          ST_READY        = 1;

  localparam logic [15:0] DIV_RESET       = 16'h0003;
  localparam logic [11:0] CTL_RESET       = 12'h000;
  localparam logic [3:0]  BIT_ONE         = 4'h1;
  localparam logic [3:0]  BITS_EIGHT      = 4'h8;
  localparam logic [3:0]  BITS_NINE       = 4'h9;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_START = 4'b0010,
    ST_DATA  = 4'b0100,
    ST_STOP  = 4'b1000
  } tx_state_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_s;

  typedef struct packed {
    logic              tx_out;
    logic              tx_oe_n;
    logic              data_out;
    logic              data_oe_n;
  } pin_out_s;

endpackage

/* verif/serial_port_transmitter_tb.sv */
// Testbench for the serial port transmitter: register tasks and a far-end model.
// Assumes a 10 MHz clock and the one-cycle strobe register port.
`timescale 1ns/1ns

module serial_port_transmitter_tb;
  localparam logic [3:0]  CTL = serial_tx_pkg::ADDR_CONTROL;
  localparam logic [3:0]  HLD = serial_tx_pkg::ADDR_HOLDING;
  localparam logic [3:0]  STA = serial_tx_pkg::ADDR_STATUS;
  localparam logic [15:0] EN  = 16'h0001 << serial_tx_pkg::CTL_ENABLE;
  localparam logic [15:0] TXE = 16'h0001 << serial_tx_pkg::CTL_TX_EN;
  localparam logic [15:0] SYN = 16'h0001 << serial_tx_pkg::CTL_SYNC;
  localparam logic [15:0] MST = 16'h0001 << serial_tx_pkg::CTL_MASTER;
  localparam logic [15:0] NIN = 16'h0001 << serial_tx_pkg::CTL_NINE;
  localparam logic [15:0] N9  = 16'h0001 << serial_tx_pkg::CTL_NINTH;
  localparam logic [15:0] POL = 16'h0001 << serial_tx_pkg::CTL_POL;
  localparam logic [15:0] IRQ = 16'h0007 << serial_tx_pkg::CTL_IRQ_EN;
  localparam logic [15:0] DIV = 16'h0005;

  logic                    clk_sys;
  logic                    resetn;
  serial_tx_pkg::reg_req_s reg_req;
  logic [15:0]             reg_rdata;
  serial_tx_pkg::pin_out_s pins;
  logic                    tx_irq;
  logic                    listen;
  logic                    sync_mode;
  logic                    pol;
  logic                    nine;
  logic [8:0]              rx_char;
  logic                    frame_err;
  logic [8:0]              exp;
  int                      rx_count;
  int                      clk_pulses;
  int                      errors;
  int                      samples_checked;
  int                      cycles;
  int                      base;
  int                      n;

  serial_port_transmitter dut (.clk_sys(clk_sys), .resetn(resetn), .reg_req(reg_req),
                               .reg_rdata(reg_rdata), .pins(pins), .tx_irq(tx_irq));
  serial_rx_model far (.clk_sys(clk_sys), .pins(pins), .listen(listen), .sync_mode(sync_mode),
                       .pol(pol), .nine(nine), .div(DIV), .rx_char(rx_char),
                       .rx_count(rx_count), .clk_pulses(clk_pulses), .frame_err(frame_err));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_req.addr  <= a;
    reg_req.wdata <= d;
    reg_req.wr    <= 1'b1;
    @(posedge clk_sys);
    reg_req.wr    <= 1'b0;
    // One idle edge so a following call never re-drives the strobe in this step
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e, input string nm);
    reg_req.addr <= a;
    reg_req.rd   <= 1'b1;
    @(posedge clk_sys);
    reg_req.rd   <= 1'b0;
    #1;
    chk(nm, e, reg_rdata);
    @(posedge clk_sys);
  endtask

  // Model is muted while the line may glitch during reconfiguration
  task automatic cfg(input logic [15:0] c);
    listen    <= 1'b0;
    wr(CTL, c);
    sync_mode <= c[serial_tx_pkg::CTL_SYNC];
    pol       <= c[serial_tx_pkg::CTL_POL];
    nine      <= c[serial_tx_pkg::CTL_NINE];
    @(posedge clk_sys);
    listen    <= 1'b1;
  endtask

  task automatic wait_rx(input logic [8:0] e, input string nm);
    int k;
    k = 0;
    n++;
    while (rx_count < n && k < 400) begin
      @(posedge clk_sys);
      k++;
    end
    chk(nm, {n[6:0], e}, {rx_count[6:0], rx_char});
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      give_verdict();
    end
  end

  initial begin
    resetn = 1'b0;
    reg_req = '0;
    {listen, sync_mode, pol, nine} = 4'h0;
    {errors, samples_checked, cycles, n} = '0;
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rd(STA, 16'h0001, "status_reset");
    rd(4'h7, 16'h0000, "unmapped_read");
    wr(serial_tx_pkg::ADDR_DIVIDER, DIV);
    cfg(EN | TXE);
    rd(STA, 16'h0003, "ready_on_enable");
    #1 chk("irq_gated", 16'h0000, {15'h0, tx_irq});
    cfg(EN | TXE | IRQ);
    #1 chk("irq_at_once", 16'h0001, {15'h0, tx_irq});
    $display("Test enable done");
    wr(HLD, 16'h00a5);
    @(posedge clk_sys);
    wr(HLD, 16'h013c);
    #1 chk("irq_busy", 16'h0000, {15'h0, tx_irq});
    rd(STA, 16'h0000, "status_busy");
    wait_rx(9'h0a5, "async_first");
    wait_rx(9'h03c, "async_second");
    repeat (6) @(posedge clk_sys);
    rd(STA, 16'h0003, "status_done");
    $display("Test async done");
    cfg(EN | TXE | NIN | N9 | POL);
    wr(HLD, 16'h0055);
    wait_rx(9'h155, "async_nine_inv");
    #1 chk("frame", 16'h0000, {15'h0, frame_err});
    $display("Test nine bit done");
    for (int p = 0; p < 2; p++) begin
      cfg(EN | TXE | SYN | MST | (p == 1 ? POL : 16'h0000));
      #1 chk("clk_idle", p[15:0], {15'h0, pins.tx_out});
      chk("oe_n", 16'h0000, {14'h0, pins.tx_oe_n, pins.data_oe_n});
      base = clk_pulses;
      exp = (p == 1) ? 9'h069 : 9'h096;
      wr(HLD, {7'h0, exp});
      wait_rx(exp, "sync_char");
      repeat (30) @(posedge clk_sys);
      #1 chk("clk_count", 16'h0008, 16'(clk_pulses - base));
      chk("clk_idle_end", p[15:0], {15'h0, pins.tx_out});
      rd(STA, 16'h0003, "status_sync");
      $display("Test sync polarity %0d done", p);
    end
    give_verdict();
  end

endmodule // serial_port_transmitter_tb

/* verif/serial_rx_model.sv */
// Far-end model: asynchronous receiver and synchronous slave watching the pins.
// Assumes the bench gives it the mode and lowers listen while it reconfigures.
`timescale 1ns/1ns

module serial_rx_model (
  // Clock
  input  wire logic                    clk_sys,
  // Line and mode
  input  wire serial_tx_pkg::pin_out_s pins,
  input  wire logic                    listen,
  input  wire logic                    sync_mode,
  input  wire logic                    pol,
  input  wire logic                    nine,
  input  wire logic [15:0]             div,
  // Results
  output logic [8:0]                   rx_char,
  output int                           rx_count,
  output int                           clk_pulses,
  output logic                         frame_err
);
  logic [8:0] sh;
  logic [8:0] ss;
  logic       ck_q;
  int         sb;

  initial begin
    rx_char = '0;
    rx_count = 0;
    clk_pulses = 0;
    frame_err = 1'b0;
    ck_q = 1'b0;
    ss = '0;
    sb = 0;
  end

  // Async: low start bit, LSB first, ninth bit last, high stop bit
  always begin
    @(posedge clk_sys);
    if (listen && !sync_mode && (pins.tx_out ^ pol) == 1'b0) begin
      sh = '0;
      repeat ((div + 1) / 2) @(posedge clk_sys);
      for (int i = 0; i < (nine ? 9 : 8); i++) begin
        repeat (div + 1) @(posedge clk_sys);
        sh[i] = pins.tx_out ^ pol;
      end
      repeat (div + 1) @(posedge clk_sys);
      if ((pins.tx_out ^ pol) !== 1'b1)
        frame_err = 1'b1;
      rx_char = sh;
      rx_count++;
    end
  end

  // Sync slave shifts on the trailing edge of the master clock
  always @(posedge clk_sys) begin
    if (listen && sync_mode && ck_q != pins.tx_out && pins.tx_out == pol) begin
      ss = {pins.data_out, ss[8:1]};
      sb++;
      clk_pulses++;
      if (sb == (nine ? 9 : 8)) begin
        rx_char = nine ? ss : {1'b0, ss[8:1]};
        rx_count++;
        sb = 0;
      end
    end
    ck_q = pins.tx_out;
  end

endmodule // serial_rx_model
